// *** hw/issc_pkg.sv ***
package issc_pkg;
  localparam int AW = 8;
  localparam int DW = 16;
  // register word indices on the plain register port
  localparam logic [7:0] ADDR_DAC_SEL = 8'h19;
  localparam logic [7:0] ADDR_TMR_SEL = 8'h1a;
  localparam logic [7:0] ADDR_CLK_CTL = 8'h1b;
  localparam logic [7:0] ADDR_PCLK_EN = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h1d;
  localparam logic [15:0] RST_VAL = 16'h0000;
  // field layout of the select registers
  localparam int DAC0_LSB = 0;
  localparam int DAC1_LSB = 4;
  localparam logic [15:0] DAC_SEL_MASK = 16'h0077;
  localparam int TIN1_BIT = 4;
  localparam int TIN2_BIT = 8;
  localparam int TIN3_BIT = 12;
  localparam logic [15:0] TMR_SEL_MASK = 16'h1110;
  // trigger source codes
  localparam logic [2:0] TRIG_ITMR0 = 3'h0;
  localparam logic [2:0] TRIG_ITMR1 = 3'h1;
  localparam logic [2:0] TRIG_ITMR2 = 3'h2;
  localparam logic [2:0] TRIG_PWMSYNC = 3'h3;
  localparam logic [2:0] TRIG_QTCH0 = 3'h4;
  localparam logic [2:0] TRIG_QTCH1 = 3'h5;
  // clock control register layout
  localparam int CC_PLL_SEL = 0;
  localparam int CC_PLL_PD = 1;
  localparam int CC_OSC_LSB = 2;
  localparam int CC_ROS_SB = 4;
  localparam int CC_ROS_PD = 5;
  localparam int CC_POST_LSB = 6;
  localparam int CC_HS_LSB = 8;
  localparam logic [15:0] CLK_CTL_MASK = 16'h0fff;
  localparam logic [15:0] CLK_CTL_RST = 16'h0002;
  localparam int NPERIPH = 8;
  localparam int NHS = 4;
  localparam logic [15:0] PCLK_RST = 16'h00ff;
  // master oscillator source codes
  localparam logic [1:0] OSC_RELAX = 2'h0;
  localparam logic [1:0] OSC_XTAL = 2'h1;
  localparam logic [1:0] OSC_EXT = 2'h2;
  // clock limits, kept for reference; no logic reads them
  localparam int MCLK_MAX_MHZ = 64;
  localparam int SYS_MAX_MHZ = 32;
  localparam int HS_MAX_MHZ = 96;
  localparam int PLL_MAX_MHZ = 196;
  localparam int ROSC_FULL_KHZ = 8000;
  localparam int ROSC_STBY_KHZ = 200;
  localparam int SYS_DIV = MCLK_MAX_MHZ / SYS_MAX_MHZ;
  typedef enum logic [2:0] {
    ROSC_FULL = 3'b001,
    ROSC_STBY = 3'b010,
    ROSC_OFF = 3'b100
  } issc_rosc_e;
endpackage

// *** hw/issc_dac_if.sv ***
`timescale 1ns/1ns
// select code out to a trigger mux, trigger back
interface issc_dac_if;
  logic [2:0] sel;
  logic trig;
  modport ctl (output sel, input trig);
  modport mux (input sel, output trig);
endinterface

// *** hw/issc_dac_mux.sv ***
`timescale 1ns/1ns
module issc_dac_mux
  import issc_pkg::*;
(
  input wire logic i_clk, // master clock
  input wire logic i_rst, // sync reset
  issc_dac_if.mux dac, // select in, trigger out
  input wire logic [2:0] i_itmr, // interval timer outs
  input wire logic i_pwm_sync, // pwm reload sync
  input wire logic i_qt_ch0, // quad timer ch0 out
  input wire logic i_qt_ch1 // quad timer ch1 out
);
  // source decode; reserved codes give a quiet low
  function automatic logic pick(input logic [2:0] s,
    input logic [2:0] it, input logic ps, input logic q0,
    input logic q1);
    case (s)
      TRIG_ITMR0: pick = it[0];
      TRIG_ITMR1: pick = it[1];
      TRIG_ITMR2: pick = it[2];
      TRIG_PWMSYNC: pick = ps;
      TRIG_QTCH0: pick = q0;
      TRIG_QTCH1: pick = q1;
      default: pick = 1'b0;
    endcase
  endfunction

  // registered so the top output is glitch free
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      dac.trig <= 1'b0;
    else
      dac.trig <= pick(dac.sel, i_itmr, i_pwm_sync,
        i_qt_ch0, i_qt_ch1);
  end
endmodule

// *** hw/issc_clk_half.sv ***
`timescale 1ns/1ns
module issc_clk_half
  import issc_pkg::*;
(
  input wire logic i_clk, // master clock
  input wire logic i_rst, // sync reset
  input wire logic i_run, // gate: high lets it toggle
  output logic o_clk_q // divided, gated clock
);
  // toggle flop halves the rate; a closed gate parks it low
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_clk_q <= 1'b0;
    else if (i_run)
      o_clk_q <= ~o_clk_q;
    else
      o_clk_q <= 1'b0;
  end
endmodule

// *** hw/issc_top.sv ***
`timescale 1ns/1ns
module issc_top
  import issc_pkg::*;
(
  input wire logic i_clk, // master clock
  input wire logic i_rst, // sync reset, high
  input wire logic [AW-1:0] i_addr, // register index
  input wire logic [DW-1:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [DW-1:0] o_rdata, // read data, next cycle
  input wire logic [2:0] i_itmr, // interval timer outs
  input wire logic i_pwm_sync, // pwm reload sync
  input wire logic i_qt_ch0, // quad timer ch0 out
  input wire logic i_qt_ch1, // quad timer ch1 out
  input wire logic [2:0] i_tmr_pin, // timer pins 1..3
  input wire logic i_cmpa, // comparator a out
  input wire logic i_cmpb, // comparator b out
  input wire logic i_wait_mode, // core clocks off
  input wire logic i_stop_mode, // system clocks off
  output logic o_dac0_trig, // dac0 sync input
  output logic o_dac1_trig, // dac1 sync input
  output logic [2:0] o_tmr_in, // timer inputs 1..3
  output logic o_sys_clk, // peripheral system clock
  output logic o_core_clk, // core and memory clock
  output logic [NPERIPH-1:0] o_pclk_en, // periph enables
  output logic [NHS-1:0] o_hs_en, // 3x clock gates
  output logic o_pll_sel, // master from pll
  output logic o_pll_pd, // pll powered down
  output logic [1:0] o_pll_post, // pll postscaler
  output logic [1:0] o_osc_src, // oscillator source
  output logic o_rosc_sb, // relax osc standby
  output logic o_rosc_pd // relax osc power down
);
  logic [DW-1:0] dac_sel_q;
  logic [DW-1:0] tmr_sel_q;
  logic [DW-1:0] clk_ctl_q;
  logic [DW-1:0] pclk_q;
  logic [DW-1:0] rd_d;
  logic [2:0] tin_d;
  logic pll_on;
  logic master_ok;
  logic [NHS-1:0] hs_d;
  issc_rosc_e rosc_q;
  issc_rosc_e rosc_d;
  issc_dac_if dac0 ();
  issc_dac_if dac1 ();

  // write hit test, shared by all register processes
  function automatic logic hit(input logic [AW-1:0] a,
    input logic [AW-1:0] r, input logic s);
    hit = s && (a == r);
  endfunction

  // dac trigger selects; reserved bits never stored
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      dac_sel_q <= RST_VAL;
    else if (hit(i_addr, ADDR_DAC_SEL, i_wr))
      dac_sel_q <= i_wdata & DAC_SEL_MASK;
  end

  // timer input selects, three single-bit fields
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      tmr_sel_q <= RST_VAL;
    else if (hit(i_addr, ADDR_TMR_SEL, i_wr))
      tmr_sel_q <= i_wdata & TMR_SEL_MASK;
  end

  // clock control: pll, oscillator, high-speed options
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      clk_ctl_q <= CLK_CTL_RST;
    else if (hit(i_addr, ADDR_CLK_CTL, i_wr))
      clk_ctl_q <= i_wdata & CLK_CTL_MASK;
  end

  // per-peripheral clock enables, all on after reset
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      pclk_q <= PCLK_RST;
    else if (hit(i_addr, ADDR_PCLK_EN, i_wr))
      pclk_q <= {{(DW-NPERIPH){1'b0}},
        i_wdata[NPERIPH-1:0]};
  end

  // read mux; unmapped indices read zero
  always_comb
  begin
    case (i_addr)
      ADDR_DAC_SEL: rd_d = dac_sel_q;
      ADDR_TMR_SEL: rd_d = tmr_sel_q;
      ADDR_CLK_CTL: rd_d = clk_ctl_q;
      ADDR_PCLK_EN: rd_d = pclk_q;
      ADDR_STATUS: rd_d = {8'h00, o_sys_clk, rosc_q,
        o_osc_src, pll_on, master_ok};
      default: rd_d = RST_VAL;
    endcase
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= RST_VAL;
    else if (i_rd)
      o_rdata <= rd_d;
    else
      o_rdata <= RST_VAL;
  end

  // dac trigger muxes share one decode module
  assign dac0.sel = dac_sel_q[DAC0_LSB +: 3];
  assign dac1.sel = dac_sel_q[DAC1_LSB +: 3];
  issc_dac_mux u_dac0 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .dac(dac0),
    .i_itmr(i_itmr),
    .i_pwm_sync(i_pwm_sync),
    .i_qt_ch0(i_qt_ch0),
    .i_qt_ch1(i_qt_ch1)
  );
  issc_dac_mux u_dac1 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .dac(dac1),
    .i_itmr(i_itmr),
    .i_pwm_sync(i_pwm_sync),
    .i_qt_ch0(i_qt_ch0),
    .i_qt_ch1(i_qt_ch1)
  );
  assign o_dac0_trig = dac0.trig;
  assign o_dac1_trig = dac1.trig;

  // timer input sources: pin when zero, internal when one
  always_comb
  begin
    tin_d[0] = tmr_sel_q[TIN1_BIT] ? i_cmpa
      : i_tmr_pin[0];
    tin_d[1] = tmr_sel_q[TIN2_BIT] ? i_cmpb
      : i_tmr_pin[1];
    tin_d[2] = tmr_sel_q[TIN3_BIT] ? i_pwm_sync
      : i_tmr_pin[2];
  end

  // registered; pin feed assumes software set one pin
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_tmr_in <= 3'h0;
    else
      o_tmr_in <= tin_d;
  end

  // relaxation oscillator state, power down has priority
  always_comb
  begin
    case (rosc_q)
      ROSC_FULL, ROSC_STBY, ROSC_OFF:
        if (clk_ctl_q[CC_ROS_PD])
          rosc_d = ROSC_OFF;
        else if (clk_ctl_q[CC_ROS_SB])
          rosc_d = ROSC_STBY;
        else
          rosc_d = ROSC_FULL;
      default: rosc_d = ROSC_FULL;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rosc_q <= ROSC_FULL;
    else
      rosc_q <= rosc_d;
  end

  // master clock exists unless code OSC_RELAX is selected and relax osc is off
  assign master_ok = !((clk_ctl_q[CC_OSC_LSB +: 2] == OSC_RELAX)
    && (rosc_q == ROSC_OFF));
  // pll must be both powered and selected
  assign pll_on = clk_ctl_q[CC_PLL_SEL]
    && !clk_ctl_q[CC_PLL_PD];

  // oscillator and pll control outputs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_osc_src <= OSC_RELAX;
      o_pll_sel <= 1'b0;
      o_pll_pd <= 1'b1;
      o_pll_post <= 2'h0;
      o_rosc_sb <= 1'b0;
      o_rosc_pd <= 1'b0;
    end
    else
    begin
      // reserved source code falls back to relax osc
      o_osc_src <= (clk_ctl_q[CC_OSC_LSB +: 2] == OSC_EXT
        || clk_ctl_q[CC_OSC_LSB +: 2] == OSC_XTAL)
        ? clk_ctl_q[CC_OSC_LSB +: 2] : OSC_RELAX;
      o_pll_sel <= pll_on;
      o_pll_pd <= clk_ctl_q[CC_PLL_PD];
      o_pll_post <= clk_ctl_q[CC_POST_LSB +: 2];
      o_rosc_sb <= (rosc_q == ROSC_STBY);
      o_rosc_pd <= (rosc_q == ROSC_OFF);
    end
  end

  // system clock: halved master, stopped in stop mode
  issc_clk_half u_sys (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(master_ok && !i_stop_mode),
    .o_clk_q(o_sys_clk)
  );
  // core clock also stops in wait mode
  issc_clk_half u_core (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(master_ok && !i_stop_mode && !i_wait_mode),
    .o_clk_q(o_core_clk)
  );

  // peripheral enables, dropped as a group in stop
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_pclk_en <= '0;
    else
      o_pclk_en <= (master_ok && !i_stop_mode)
        ? pclk_q[NPERIPH-1:0] : '0;
  end

  // 3x gates: pwm, timer a, timer b, i2c
  genvar g;
  generate
    for (g = 0; g < NHS; g++)
    begin : g_hs
      // without a running pll there is no 3x clock to pass
      assign hs_d[g] = pclk_q[g] && clk_ctl_q[CC_HS_LSB + g]
        && pll_on && master_ok && !i_stop_mode;
    end
  endgenerate

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_hs_en <= '0;
    else
      o_hs_en <= hs_d;
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_dac_resv_low: assert property (
    dac0.sel[2:1] == 2'b11 |=> !o_dac0_trig)
    else $error("reserved dac code did not force low");
  a_dac1_pwm: assert property (
    dac1.sel == TRIG_PWMSYNC |=> o_dac1_trig == $past(i_pwm_sync))
    else $error("dac1 pwm sync not forwarded");
  a_dac0_itmr1: assert property (
    dac0.sel == TRIG_ITMR1 |=> o_dac0_trig == $past(i_itmr[1]))
    else $error("dac0 timer1 not forwarded");
  a_dac_resv_bits: assert property (
    (dac_sel_q & ~DAC_SEL_MASK) == RST_VAL)
    else $error("dac select reserved bit set");
  a_tmr_resv_bits: assert property (
    i_rd && i_addr == ADDR_TMR_SEL
      |=> (o_rdata & ~TMR_SEL_MASK) == RST_VAL)
    else $error("timer select reserved bit read nonzero");
  a_tin3_src: assert property (
    tmr_sel_q[TIN3_BIT] |=> o_tmr_in[2] == $past(i_pwm_sync))
    else $error("timer input 3 not pwm sync");
  a_tin2_src: assert property (
    !tmr_sel_q[TIN2_BIT] |=> o_tmr_in[1] == $past(i_tmr_pin[1]))
    else $error("timer input 2 not pin");
  a_tin1_src: assert property (
    tmr_sel_q[TIN1_BIT] |=> o_tmr_in[0] == $past(i_cmpa))
    else $error("timer input 1 not comparator a");
  a_sys_halve: assert property (
    master_ok && !i_stop_mode && $past(master_ok && !i_stop_mode)
      && !$past(i_rst) |=> o_sys_clk != $past(o_sys_clk))
    else $error("system clock not halving master");
  a_sys_stop: assert property (
    i_stop_mode |=> !o_sys_clk)
    else $error("system clock runs in stop");
  a_hs_needs_pll: assert property (
    !pll_on |=> o_hs_en == '0)
    else $error("3x gate open without pll");
  a_hs_open: assert property (
    hs_d[0] |=> o_hs_en[0])
    else $error("pwm 3x gate did not open");
  a_rosc_pd: assert property (
    clk_ctl_q[CC_ROS_PD] [*2] |=> o_rosc_pd && !o_rosc_sb)
    else $error("relax osc not powered down");
  a_pclk_off: assert property (
    !pclk_q[1] |=> !o_pclk_en[1])
    else $error("disabled peripheral clock still on");
  a_pll_sel: assert property (
    clk_ctl_q[CC_PLL_PD] |=> !o_pll_sel)
    else $error("pll selected while powered down");
  // read path, the other source legs and the power gates
  a_dac_resv_read: assert property (
    i_rd && i_addr == ADDR_DAC_SEL
      |=> (o_rdata & ~DAC_SEL_MASK) == RST_VAL)
    else $error("dac select reserved bit read nonzero");
  a_tin3_pin: assert property (
    !tmr_sel_q[TIN3_BIT] |=> o_tmr_in[2] == $past(i_tmr_pin[2]))
    else $error("timer input 3 not pin");
  a_tin2_cmp: assert property (
    tmr_sel_q[TIN2_BIT] |=> o_tmr_in[1] == $past(i_cmpb))
    else $error("timer input 2 not comparator b");
  a_tin1_pin: assert property (
    !tmr_sel_q[TIN1_BIT] |=> o_tmr_in[0] == $past(i_tmr_pin[0]))
    else $error("timer input 1 not pin");
  a_core_wait: assert property (
    i_wait_mode |=> !o_core_clk)
    else $error("core clock runs in wait");
  a_rosc_stby: assert property (
    (!clk_ctl_q[CC_ROS_PD] && clk_ctl_q[CC_ROS_SB]) [*2]
      |=> o_rosc_sb && !o_rosc_pd)
    else $error("relax osc not in standby");
  a_hs_stop: assert property (
    i_stop_mode |=> o_hs_en == '0 && o_pclk_en == '0)
    else $error("clock gates open in stop");
  a_pclk_on: assert property (
    pclk_q[0] && master_ok && !i_stop_mode |=> o_pclk_en[0])
    else $error("enabled peripheral clock stays off");

  c_dac_pwm: cover property (dac1.sel == TRIG_PWMSYNC
    ##1 o_dac1_trig);
  c_tin3_sync: cover property (tmr_sel_q[TIN3_BIT]
    && i_pwm_sync ##1 o_tmr_in[2]);
  c_hs_on: cover property (o_hs_en[1]);
  c_rosc_stby: cover property (o_rosc_sb);
  c_dac_resv: cover property (dac0.sel[2:1] == 2'b11
    ##1 !o_dac0_trig);
endmodule

// *** dv/issc_src_model.sv ***
`timescale 1ns/1ns
module issc_src_model
(
  input wire logic i_clk, // master clock
  input wire logic i_rst, // sync reset
  output logic [2:0] o_itmr, // interval timer outs
  output logic o_pwm_sync, // pwm reload sync
  output logic o_qt_ch0, // quad timer ch0 out
  output logic o_qt_ch1, // quad timer ch1 out
  output logic [2:0] o_tmr_pin, // timer pins 1..3
  output logic o_cmpa, // comparator a out
  output logic o_cmpb // comparator b out
);
  logic [15:0] seq_q;
  // shift pattern: every source is a delayed copy, so a wrong pick shows
  // pwm and timers share this one clock, so sync is seen at one rate
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      seq_q <= 16'h0001;
    else
      seq_q <= {seq_q[14:0], seq_q[15] ^ seq_q[14] ^ seq_q[12] ^ seq_q[3]};
  end
  // one driver per timer pin, never two pins on one input
  assign o_itmr = seq_q[2:0];
  assign o_pwm_sync = seq_q[3];
  assign o_qt_ch0 = seq_q[4];
  assign o_qt_ch1 = seq_q[5];
  assign o_tmr_pin = seq_q[8:6];
  assign o_cmpa = seq_q[9];
  assign o_cmpb = seq_q[10];
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  import issc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_wait_mode = 1'b0;
  logic i_stop_mode = 1'b0;
  logic [15:0] o_rdata, rd_v;
  logic [2:0] i_itmr, i_tmr_pin, o_tmr_in;
  logic i_pwm_sync, i_qt_ch0, i_qt_ch1, i_cmpa, i_cmpb;
  logic o_dac0_trig, o_dac1_trig, o_sys_clk, o_core_clk;
  logic [7:0] o_pclk_en;
  logic [3:0] o_hs_en;
  logic o_pll_sel, o_pll_pd, o_rosc_sb, o_rosc_pd;
  logic [1:0] o_pll_post, o_osc_src;
  logic [10:0] src_prev;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  issc_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_itmr(i_itmr), .i_pwm_sync(i_pwm_sync), .i_qt_ch0(i_qt_ch0),
    .i_qt_ch1(i_qt_ch1), .i_tmr_pin(i_tmr_pin), .i_cmpa(i_cmpa),
    .i_cmpb(i_cmpb), .i_wait_mode(i_wait_mode), .i_stop_mode(i_stop_mode),
    .o_dac0_trig(o_dac0_trig), .o_dac1_trig(o_dac1_trig),
    .o_tmr_in(o_tmr_in), .o_sys_clk(o_sys_clk), .o_core_clk(o_core_clk),
    .o_pclk_en(o_pclk_en), .o_hs_en(o_hs_en), .o_pll_sel(o_pll_sel),
    .o_pll_pd(o_pll_pd), .o_pll_post(o_pll_post), .o_osc_src(o_osc_src),
    .o_rosc_sb(o_rosc_sb), .o_rosc_pd(o_rosc_pd));
  issc_src_model src_u (.i_clk(i_clk), .i_rst(i_rst), .o_itmr(i_itmr),
    .o_pwm_sync(i_pwm_sync), .o_qt_ch0(i_qt_ch0), .o_qt_ch1(i_qt_ch1),
    .o_tmr_pin(i_tmr_pin), .o_cmpa(i_cmpa), .o_cmpb(i_cmpb));
  // clock, plus the source values each edge saw, for expectations
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    src_prev <= {i_cmpb, i_cmpa, i_tmr_pin, i_qt_ch1, i_qt_ch0, i_pwm_sync,
      i_itmr};
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures = failures + 1;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
    input string msg);
    checks = checks + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // register port: strobe one cycle, read data in the following cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e,
    input string msg);
    rd(a, rd_v);
    chk(rd_v, e, msg);
  endtask
  function automatic logic pick(input logic [2:0] c, input logic [10:0] s);
    pick = (c < 3'h6) ? s[c] : 1'b0;
  endfunction
  task automatic t_reset();
    rchk(ADDR_DAC_SEL, 16'h0000, "dac sel reset");
    rchk(ADDR_TMR_SEL, 16'h0000, "tmr sel reset");
    rchk(ADDR_CLK_CTL, 16'h0002, "clk ctl reset");
    rchk(ADDR_PCLK_EN, 16'h00ff, "pclk reset");
    chk(16'({o_pll_pd, o_pll_sel, o_hs_en}), 16'h0020, "pll reset");
  endtask
  task automatic t_masks();
    wr(ADDR_DAC_SEL, 16'hffff);
    wr(ADDR_TMR_SEL, 16'hffff);
    wr(8'h05, 16'hffff);
    rchk(ADDR_DAC_SEL, 16'h0077, "dac reserved");
    @(negedge i_clk);
    chk(o_rdata, 16'h0000, "rdata one cycle");
    rchk(ADDR_TMR_SEL, 16'h1110, "tmr reserved");
    rchk(8'h05, 16'h0000, "unmapped read");
  endtask
  // each code on both fields, other field offset so fields stay apart
  task automatic t_dac();
    logic [2:0] c1;
    for (int c = 0; c < 8; c++)
    begin
      c1 = 3'(c + 3);
      wr(ADDR_DAC_SEL, {9'h000, c1, 1'b0, 3'(c)});
      repeat (3) @(negedge i_clk);
      repeat (12)
      begin
        @(negedge i_clk);
        chk(16'(o_dac0_trig), 16'(pick(3'(c), src_prev)), "dac0");
        chk(16'(o_dac1_trig), 16'(pick(c1, src_prev)), "dac1");
      end
    end
  endtask
  task automatic t_tmr();
    logic [2:0] e;
    for (int m = 0; m < 8; m++)
    begin
      wr(ADDR_TMR_SEL, {3'h0, m[2], 3'h0, m[1], 3'h0, m[0], 4'h0});
      repeat (3) @(negedge i_clk);
      repeat (12)
      begin
        @(negedge i_clk);
        e[0] = m[0] ? src_prev[9] : src_prev[6];
        e[1] = m[1] ? src_prev[10] : src_prev[7];
        e[2] = m[2] ? src_prev[3] : src_prev[8];
        chk(16'(o_tmr_in), 16'(e), "tmr inputs");
      end
    end
  endtask
  // system clock toggles every edge while running, parks low when gated
  task automatic watch(input logic sys_on, input logic core_on);
    logic ps;
    logic pc;
    @(negedge i_clk);
    ps = o_sys_clk;
    pc = o_core_clk;
    repeat (4)
    begin
      @(negedge i_clk);
      chk(16'(o_sys_clk), 16'(sys_on & !ps), "sys clk");
      chk(16'(o_core_clk), 16'(core_on & !pc), "core clk");
      ps = o_sys_clk;
      pc = o_core_clk;
    end
  endtask
  task automatic t_clocks();
    watch(1'b1, 1'b1);
    wr(ADDR_CLK_CTL, 16'h0f02);
    repeat (3) @(negedge i_clk);
    chk(16'(o_hs_en), 16'h0000, "hs without pll");
    wr(ADDR_CLK_CTL, 16'h0f01);
    repeat (3) @(negedge i_clk);
    chk(16'({o_pll_pd, o_pll_sel, o_hs_en}), 16'h001f, "hs pll");
    wr(ADDR_PCLK_EN, 16'h00f6);
    repeat (3) @(negedge i_clk);
    chk(16'({o_hs_en, o_pclk_en}), 16'h06f6, "pclk gates");
    @(posedge i_clk);
    i_wait_mode <= 1'b1;
    repeat (3) @(negedge i_clk);
    watch(1'b1, 1'b0);
    @(posedge i_clk);
    i_stop_mode <= 1'b1;
    repeat (3) @(negedge i_clk);
    watch(1'b0, 1'b0);
    chk(16'({o_hs_en, o_pclk_en}), 16'h0000, "stop gates");
    @(posedge i_clk);
    i_wait_mode <= 1'b0;
    i_stop_mode <= 1'b0;
    wr(ADDR_PCLK_EN, 16'h00ff);
    repeat (3) @(negedge i_clk);
    watch(1'b1, 1'b1);
  endtask
  task automatic t_osc();
    for (int o = 0; o < 4; o++)
    begin
      wr(ADDR_CLK_CTL, 16'(o << 2) | 16'h0082);
      repeat (2) @(negedge i_clk);
      chk(16'({o_pll_post, o_osc_src}), 16'(8 + o % 3), "osc");
      rd(ADDR_STATUS, rd_v);
      chk(16'(rd_v[3:2]), 16'(o % 3), "status osc");
    end
    wr(ADDR_CLK_CTL, 16'h0012);
    repeat (3) @(negedge i_clk);
    chk(16'({o_rosc_sb, o_rosc_pd}), 16'h0002, "relax standby");
    rd(ADDR_STATUS, rd_v);
    chk(16'(rd_v[6:4]), 16'h0002, "status standby");
    wr(ADDR_CLK_CTL, 16'h0032);
    repeat (3) @(negedge i_clk);
    rd(ADDR_STATUS, rd_v);
    chk(16'({rd_v[6:4], rd_v[0]}), 16'h0008, "relax off");
    chk(16'({o_rosc_sb, o_rosc_pd}), 16'h0001, "relax pd");
    watch(1'b0, 1'b0);
    wr(ADDR_CLK_CTL, 16'h0002);
    repeat (3) @(negedge i_clk);
    watch(1'b1, 1'b1);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // reset for five edges, then scenarios in turn
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    t_reset();
    t_masks();
    t_dac();
    t_tmr();
    t_clocks();
    t_osc();
    summarize();
  end
endmodule
